// ---- rtl/pin_function_mux.sv ----
// pin function multiplexer for ports 1 to 5 with its ten select registers
// assumes register strobes and peripheral drives are synchronous to ref_clk; pads are not
//
// Strobed register access was decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - each pin has a 2-bit select field, four per byte, reset to port use.
// - port1 pin3 code 2 gives analog input 7; other nonzero codes reserved.
// - port1 pins 4-6 code 2 give analog inputs 6, 5, 4; rest reserved.
// - port2 pins 0-3 have no alternate function; codes 1 to 3 reserved.
// - port2 pins 4-7 code 1 give serial tx and rfc lines; pin7 code 2 rfc input 1.
// - port3 pins 3 and 2 carry twi clock, twi data, rfc sensor and pwm lines.
// - port3 pins 1 and 0 carry twi clock, rfc sensor, pwm, serial rx, rfc reference.
// - port3 pins 7 and 6 carry timer outputs, lcd frame, rfc clock; code 0 adds ext clock.
// - port3 pin5 gives osc1 clock or low-active output; pin4 twi data or pwm.
// - pwm choices and external clock inputs exist only with the extra timer channels.
// - port4 pins 0-3 code 1 give high-speed clock out and debug lines.
// - port4 pins 4-7 code 1 give twi clock, twi data, rfc clock b, timer out 4.
// - port5 pins 0-3 give serial ch1 lines, low-active output, pwm ch5 lines.
// - port5 pins 4-6 give lcd frame (code 1), pwm ch6 a and b (code 2).
// - top two bits of last register pick pins for external count clocks 6 and 5.
module pin_function_mux #(
   parameter bit HAS_EXTRA_TIMER = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire pin_function_mux_pkg::reg_req_t bus_req,
   output logic [7:0] bus_rdata,
   // general-purpose port side
   input wire pin_function_mux_pkg::pin_drive_t gpio_drive,
   output logic [pin_function_mux_pkg::N_PINS-1:0] gpio_in,
   // peripheral side
   input wire pin_function_mux_pkg::func_drive_t periph_drive,
   output logic [pin_function_mux_pkg::N_FUNCS-1:0] periph_in,
   output logic [pin_function_mux_pkg::N_FUNCS-1:0] periph_routed,
   output logic ext_count_clk_ch5,
   output logic ext_count_clk_ch6,
   // pads
   input wire logic [pin_function_mux_pkg::N_PINS-1:0] pad_in,
   output pin_function_mux_pkg::pin_drive_t pad_drive
);
   import pin_function_mux_pkg::*;

   // function per pin and per code; reserved codes map to port use
   localparam func_t FUNC_MAP [N_PINS][4] = '{
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p10
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p11
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p12
      '{FN_PORT, FN_PORT, FN_ANALOG_INPUT_CH7, FN_PORT},                  // p13
      '{FN_PORT, FN_PORT, FN_ANALOG_INPUT_CH6, FN_PORT},                  // p14
      '{FN_PORT, FN_PORT, FN_ANALOG_INPUT_CH5, FN_PORT},                  // p15
      '{FN_PORT, FN_PORT, FN_ANALOG_INPUT_CH4, FN_PORT},                  // p16
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p17
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p20
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p21
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p22
      '{FN_PORT, FN_PORT, FN_PORT, FN_PORT},                              // p23
      '{FN_PORT, FN_RFC_SENSOR_A_CH0, FN_PORT, FN_PORT},                  // p24
      '{FN_PORT, FN_RFC_REFERENCE_CH0, FN_PORT, FN_PORT},                 // p25
      '{FN_PORT, FN_RFC_INPUT_CH0, FN_PORT, FN_PORT},                     // p26
      '{FN_PORT, FN_SERIAL_TX_CH1, FN_RFC_INPUT_CH1, FN_PORT},            // p27
      '{FN_PORT, FN_SERIAL_RX_CH1, FN_RFC_REFERENCE_CH1, FN_PORT},        // p30
      '{FN_PORT, FN_TWI_CLOCK_CH0, FN_RFC_SENSOR_A_CH1, FN_PWM_A_CH5_PIN}, // p31
      '{FN_PORT, FN_TWI_DATA_CH0, FN_RFC_SENSOR_B_CH1, FN_PWM_B_CH5_PIN}, // p32
      '{FN_PORT, FN_TWI_CLOCK_CH1, FN_TWI_CLOCK_CH0, FN_PWM_A_CH6_PIN},   // p33
      '{FN_PORT, FN_TWI_DATA_CH1, FN_TWI_DATA_CH0, FN_PWM_B_CH6_PIN},     // p34
      '{FN_PORT, FN_OSC1_CLOCK_OUT, FN_MISC_LOW_ACTIVE_OUT, FN_PORT},     // p35
      '{FN_PORT, FN_TIMER8_OUT_CH3, FN_RFC_CLOCK_OUT_A, FN_PORT},         // p36
      '{FN_PORT, FN_TIMER8_OUT_INV_CH3, FN_LCD_FRAME_OUT, FN_TIMER8_OUT_CH4}, // p37
      '{FN_PORT, FN_HS_CLOCK_OUT, FN_PORT, FN_PORT},                      // p40
      '{FN_PORT, FN_DEBUG_SERIAL_IO, FN_PORT, FN_PORT},                   // p41
      '{FN_PORT, FN_DEBUG_STATUS, FN_PORT, FN_PORT},                      // p42
      '{FN_PORT, FN_DEBUG_CLOCK, FN_PORT, FN_PORT},                       // p43
      '{FN_PORT, FN_TWI_CLOCK_CH1, FN_PORT, FN_PORT},                     // p44
      '{FN_PORT, FN_TWI_DATA_CH1, FN_PORT, FN_PORT},                      // p45
      '{FN_PORT, FN_RFC_CLOCK_OUT_B, FN_PORT, FN_PORT},                   // p46
      '{FN_PORT, FN_TIMER8_OUT_CH4, FN_PORT, FN_PORT},                    // p47
      '{FN_PORT, FN_SERIAL_CLK_CH1, FN_PORT, FN_PORT},                    // p50
      '{FN_PORT, FN_SERIAL_TX_CH1, FN_PWM_A_CH5_PIN, FN_PORT},            // p51
      '{FN_PORT, FN_SERIAL_RX_CH1, FN_PWM_B_CH5_PIN, FN_PORT},            // p52
      '{FN_PORT, FN_MISC_LOW_ACTIVE_OUT, FN_PORT, FN_PORT},               // p53
      '{FN_PORT, FN_LCD_FRAME_OUT, FN_PORT, FN_PORT},                     // p54
      '{FN_PORT, FN_PORT, FN_PWM_A_CH6_PIN, FN_PORT},                     // p55
      '{FN_PORT, FN_PORT, FN_PWM_B_CH6_PIN, FN_PORT}                      // p56
   };

   // select registers and pad synchroniser
   logic [7:0] sel_reg [N_REGS];
   logic [N_PINS-1:0] pad_meta;
   logic [N_PINS-1:0] pad_sync;

   // register decode
   wire logic [15:0] reg_offset = bus_req.addr - PORT1_LOW_PIN_FUNCTION_OFS;
   wire logic reg_hit = (bus_req.addr >= PORT1_LOW_PIN_FUNCTION_OFS) &&
                        (bus_req.addr <= PORT5_HIGH_PIN_FUNCTION_AND_CLOCK_SOURCE_OFS);
   wire logic [3:0] reg_idx = reg_offset[3:0];
   wire logic [7:0] next_bus_rdata = (bus_req.rd && reg_hit) ? sel_reg[reg_idx] : READ_IDLE;

   // clock source selects live in the top two bits of the last register
   wire logic [7:0] last_reg = sel_reg[N_REGS-1];
   wire logic ext_clk6_pin_sel = last_reg[EXT_CLK6_PIN_SEL_BIT];
   wire logic ext_clk5_pin_sel = last_reg[EXT_CLK5_PIN_SEL_BIT];

   // per-pin function after reserved and model gating
   func_t pin_fn [N_PINS];
   logic [FIELD_W-1:0] pin_code [N_PINS];
   logic [N_PINS-1:0] next_pad_out;
   logic [N_PINS-1:0] next_pad_oe;

   for (genvar p = 0; p < N_PINS; p++) begin : g_pin
      wire func_t raw_fn;
      wire logic is_pwm;
      // field position follows the pin's place within its register
      assign pin_code[p] = sel_reg[p / PINS_PER_REG][FIELD_W*(p % PINS_PER_REG) +: FIELD_W];
      assign raw_fn = FUNC_MAP[p][pin_code[p]];
      assign is_pwm = (raw_fn == FN_PWM_A_CH5_PIN) || (raw_fn == FN_PWM_B_CH5_PIN) ||
                      (raw_fn == FN_PWM_A_CH6_PIN) || (raw_fn == FN_PWM_B_CH6_PIN);
      // without the extra timer channels the pwm choices fall back to port
      assign pin_fn[p] = (is_pwm && !HAS_EXTRA_TIMER) ? FN_PORT : raw_fn;
      // port use takes the gpio drive, anything else the chosen peripheral
      assign next_pad_out[p] = (pin_fn[p] == FN_PORT) ? gpio_drive.out[p] :
                               periph_drive.out[pin_fn[p]];
      assign next_pad_oe[p] = (pin_fn[p] == FN_PORT) ? gpio_drive.oe[p] :
                              periph_drive.oe[pin_fn[p]];
   end

   // per-function input gather; a function on two pins sees the or of both
   logic [N_FUNCS-1:0] next_periph_in;
   logic [N_FUNCS-1:0] next_periph_routed;

   for (genvar f = 0; f < N_FUNCS; f++) begin : g_func
      logic [N_PINS-1:0] on_pin;
      for (genvar p = 0; p < N_PINS; p++) begin : g_hit
         assign on_pin[p] = (pin_fn[p] == func_t'(f));
      end
      assign next_periph_in[f] = |(on_pin & pad_sync);
      assign next_periph_routed[f] = |on_pin;
   end

   // external count clocks: only taken from a pin left on port use
   wire logic clk6_src_pin = ext_clk6_pin_sel ? pad_sync[PIN_P50] : pad_sync[PIN_P37];
   wire logic clk6_src_port = ext_clk6_pin_sel ? (pin_code[PIN_P50] == CODE_PORT) :
                                                 (pin_code[PIN_P37] == CODE_PORT);
   wire logic clk5_src_pin = ext_clk5_pin_sel ? pad_sync[PIN_P47] : pad_sync[PIN_P36];
   wire logic clk5_src_port = ext_clk5_pin_sel ? (pin_code[PIN_P47] == CODE_PORT) :
                                                 (pin_code[PIN_P36] == CODE_PORT);
   // software picks the right select bit; hardware just follows it
   wire logic next_ext6 = HAS_EXTRA_TIMER && clk6_src_port && clk6_src_pin;
   wire logic next_ext5 = HAS_EXTRA_TIMER && clk5_src_port && clk5_src_pin;

   // register writes, byte wide, every bit defined
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < N_REGS; i++) begin
         if (!rst_n) begin
            sel_reg[i] <= PIN_FUNCTION_RESET;
         end else if (bus_req.wr && reg_hit && (reg_idx == 4'(i))) begin
            sel_reg[i] <= bus_req.wdata;
         end
      end
   end

   // two-flop pad synchroniser; the first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pad_meta <= '0;
         pad_sync <= '0;
      end else begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
      end
   end

   // registered outputs; one cycle added so every output leaves a flip-flop
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus_rdata <= READ_IDLE;
         pad_drive <= '0;
         gpio_in <= '0;
         periph_in <= '0;
         periph_routed <= '0;
         ext_count_clk_ch5 <= 1'b0;
         ext_count_clk_ch6 <= 1'b0;
      end else begin
         bus_rdata <= next_bus_rdata;
         pad_drive.out <= next_pad_out;
         pad_drive.oe <= next_pad_oe;
         gpio_in <= pad_sync;
         periph_in <= next_periph_in;
         periph_routed <= next_periph_routed;
         ext_count_clk_ch5 <= next_ext5;
         ext_count_clk_ch6 <= next_ext6;
      end
   end

endmodule

// ---- rtl/pin_function_mux_pkg.sv ----
// package for the pin function multiplexer: register map, function codes, carriers
// assumes one byte-wide register port and pins of ports 1 to 5 in a flat index
package pin_function_mux_pkg;

   // pin numbering: port1 0-7, port2 8-15, port3 16-23, port4 24-31, port5 32-38
   localparam int N_PINS = 39;
   localparam int N_REGS = 10;
   localparam int FIELD_W = 2;
   localparam int PINS_PER_REG = 4;

   // register offsets, one byte each
   localparam logic [15:0] PORT1_LOW_PIN_FUNCTION_OFS = 16'h52a2;
   localparam logic [15:0] PORT1_HIGH_PIN_FUNCTION_OFS = 16'h52a3;
   localparam logic [15:0] PORT2_LOW_PIN_FUNCTION_OFS = 16'h52a4;
   localparam logic [15:0] PORT2_HIGH_PIN_FUNCTION_OFS = 16'h52a5;
   localparam logic [15:0] PORT3_LOW_PIN_FUNCTION_OFS = 16'h52a6;
   localparam logic [15:0] PORT3_HIGH_PIN_FUNCTION_OFS = 16'h52a7;
   localparam logic [15:0] PORT4_LOW_PIN_FUNCTION_OFS = 16'h52a8;
   localparam logic [15:0] PORT4_HIGH_PIN_FUNCTION_OFS = 16'h52a9;
   localparam logic [15:0] PORT5_LOW_PIN_FUNCTION_OFS = 16'h52aa;
   localparam logic [15:0] PORT5_HIGH_PIN_FUNCTION_AND_CLOCK_SOURCE_OFS = 16'h52ab;

   // reset values and field layout
   localparam logic [7:0] PIN_FUNCTION_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;
   localparam int EXT_CLK6_PIN_SEL_BIT = 7;
   localparam int EXT_CLK5_PIN_SEL_BIT = 6;
   localparam logic [1:0] CODE_PORT = 2'h0;

   // pins that can feed the external count clocks
   localparam int PIN_P36 = 22;
   localparam int PIN_P37 = 23;
   localparam int PIN_P47 = 31;
   localparam int PIN_P50 = 32;

   // functions a pin can carry; fn_port is plain general-purpose use
   typedef enum logic [5:0] {
      FN_PORT, FN_ANALOG_INPUT_CH4, FN_ANALOG_INPUT_CH5, FN_ANALOG_INPUT_CH6,
      FN_ANALOG_INPUT_CH7, FN_SERIAL_TX_CH1, FN_SERIAL_RX_CH1, FN_SERIAL_CLK_CH1,
      FN_RFC_INPUT_CH0, FN_RFC_INPUT_CH1, FN_RFC_REFERENCE_CH0, FN_RFC_REFERENCE_CH1,
      FN_RFC_SENSOR_A_CH0, FN_RFC_SENSOR_A_CH1, FN_RFC_SENSOR_B_CH1,
      FN_TWI_CLOCK_CH0, FN_TWI_CLOCK_CH1, FN_TWI_DATA_CH0, FN_TWI_DATA_CH1,
      FN_PWM_A_CH5_PIN, FN_PWM_B_CH5_PIN, FN_PWM_A_CH6_PIN, FN_PWM_B_CH6_PIN,
      FN_TIMER8_OUT_CH3, FN_TIMER8_OUT_INV_CH3, FN_TIMER8_OUT_CH4, FN_LCD_FRAME_OUT,
      FN_RFC_CLOCK_OUT_A, FN_RFC_CLOCK_OUT_B, FN_MISC_LOW_ACTIVE_OUT, FN_OSC1_CLOCK_OUT,
      FN_HS_CLOCK_OUT, FN_DEBUG_CLOCK, FN_DEBUG_STATUS, FN_DEBUG_SERIAL_IO
   } func_t;
   localparam int N_FUNCS = 35;

   // drive towards pins, one bit per pin
   typedef struct packed {
      logic [N_PINS-1:0] out;
      logic [N_PINS-1:0] oe;
   } pin_drive_t;

   // drive from peripherals, one bit per function code
   typedef struct packed {
      logic [N_FUNCS-1:0] out;
      logic [N_FUNCS-1:0] oe;
   } func_drive_t;

   // register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// ---- testbench/pin_function_mux_props.sv ----
// property checker for the pin function multiplexer, bound to its top ports
// assumes one clock ref_clk and the synchronous active-low rst_n
`timescale 1ns/100ps
module pin_function_mux_props #(
   parameter bit HAS_EXTRA_TIMER = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire pin_function_mux_pkg::reg_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // drives and pads
   input wire pin_function_mux_pkg::pin_drive_t gpio_drive,
   input wire logic [pin_function_mux_pkg::N_PINS-1:0] gpio_in,
   input wire pin_function_mux_pkg::func_drive_t periph_drive,
   input wire logic [pin_function_mux_pkg::N_FUNCS-1:0] periph_routed,
   input wire logic ext_count_clk_ch5,
   input wire logic ext_count_clk_ch6,
   input wire logic [pin_function_mux_pkg::N_PINS-1:0] pad_in,
   input wire pin_function_mux_pkg::pin_drive_t pad_drive
);
   import pin_function_mux_pkg::*;
   logic [7:0] sh [N_REGS];
   logic [2:0] up;
   // shadow decode; idx is only meaningful while hit is high
   wire hit = bus_req.addr >= 16'h52a2 && bus_req.addr <= 16'h52ab;
   wire [3:0] idx = 4'(bus_req.addr - 16'h52a2);
   wire [7:0] rsel = sh[idx];
   wire an7 = sh[0][7:6] == 2'h2;
   wire tx1 = sh[3][7:6] == 2'h1 || sh[8][3:2] == 2'h1;
   wire e5 = HAS_EXTRA_TIMER && (sh[9][6] ? sh[7][7:6] == 2'h0 : sh[5][5:4] == 2'h0);
   wire e6 = HAS_EXTRA_TIMER && (sh[9][7] ? sh[8][1:0] == 2'h0 : sh[5][7:6] == 2'h0);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // shadow of the select bytes; up counts edges so deep $past never sees reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sh <= '{default: 8'h00};
         up <= 3'h0;
      end else begin
         if (bus_req.wr && hit) sh[idx] <= bus_req.wdata;
         if (up != 3'h7) up <= up + 3'h1;
      end
   end
   a_reset_clear: assert property (!$past(rst_n) |-> bus_rdata == 8'h00 && pad_drive == '0)
      else $error("outputs not clear after reset");
   a_rdata_hit: assert property ($past(bus_req.rd && hit) |-> bus_rdata == $past(rsel))
      else $error("read data differs from last write");
   a_rdata_idle: assert property (!$past(bus_req.rd && hit) |-> bus_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_fixed_pins: assert property (up != 3'h0 |-> pad_drive.out[11:7] == $past(gpio_drive.out[11:7])
      && pad_drive.oe[11:7] == $past(gpio_drive.oe[11:7]))
      else $error("port-only pin not on gpio");
   a_analog_route: assert property (periph_routed[FN_ANALOG_INPUT_CH7] == $past(an7))
      else $error("analog input 7 routing wrong");
   a_pin3_drive: assert property (up != 3'h0 |-> {pad_drive.out[3], pad_drive.oe[3]} == $past(an7 ?
      {periph_drive.out[4], periph_drive.oe[4]} : {gpio_drive.out[3], gpio_drive.oe[3]}))
      else $error("pin 3 drive source wrong");
   a_serial_tx: assert property (periph_routed[FN_SERIAL_TX_CH1] == $past(tx1))
      else $error("serial tx routing wrong");
   a_gpio_sync: assert property (up > 3'h2 |-> gpio_in == $past(pad_in, 3))
      else $error("gpio input not the pad level");
   a_ext_clk5: assert property (up > 3'h2 |-> ext_count_clk_ch5 == ($past(e5) && ($past(sh[9][6])
      ? $past(pad_in[PIN_P47], 3) : $past(pad_in[PIN_P36], 3))))
      else $error("count clock 5 source wrong");
   a_ext_clk6: assert property (up > 3'h2 |-> ext_count_clk_ch6 == ($past(e6) && ($past(sh[9][7])
      ? $past(pad_in[PIN_P50], 3) : $past(pad_in[PIN_P37], 3))))
      else $error("count clock 6 source wrong");
   c_analog: cover property (periph_routed[FN_ANALOG_INPUT_CH7]);
   c_clk5_alt: cover property (sh[9][6] && ext_count_clk_ch5);
   c_read: cover property (bus_req.rd && hit ##1 bus_rdata != 8'h00);
endmodule
bind pin_function_mux pin_function_mux_props #(.HAS_EXTRA_TIMER(HAS_EXTRA_TIMER)) i_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .gpio_drive(gpio_drive), .gpio_in(gpio_in), .periph_drive(periph_drive),
   .periph_routed(periph_routed), .ext_count_clk_ch5(ext_count_clk_ch5),
   .ext_count_clk_ch6(ext_count_clk_ch6), .pad_in(pad_in), .pad_drive(pad_drive));

// ---- testbench/pad_model.sv ----
// pad model: the board side of every multiplexed pin
// assumes outside parts drive a pin only while the mux leaves it released
`timescale 1ns/100ps
module pad_model (
   // pad drive from the mux
   input wire pin_function_mux_pkg::pin_drive_t pad_drive,
   // level outside parts put on released pins
   input wire logic [pin_function_mux_pkg::N_PINS-1:0] ext_level,
   // resolved level back into the mux
   output logic [pin_function_mux_pkg::N_PINS-1:0] pad_in
);
   import pin_function_mux_pkg::*;
   // released pins take a level redrawn at random every cycle, so a stale value is soon exposed
   assign pad_in = (pad_drive.oe & pad_drive.out) | (~pad_drive.oe & ext_level);
endmodule

// ---- testbench/pin_function_mux_tb.sv ----
// testbench for the pin function multiplexer: registers, routing table, clock pins
// assumes the pad model closes the loop from pad drive to pad input
`timescale 1ns/100ps
module pin_function_mux_tb;
   import pin_function_mux_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   reg_req_t bus_req = '0;
   pin_drive_t gpio_drive = '0;
   func_drive_t periph_drive = '0;
   logic [N_PINS-1:0] ext_level = '0;
   logic [7:0] bus_rdata;
   logic [N_PINS-1:0] gpio_in, pad_in;
   logic [N_FUNCS-1:0] periph_in, periph_routed;
   logic ext_count_clk_ch5, ext_count_clk_ch6;
   pin_drive_t pad_drive;
   logic [31:0] seed = 32'h1924_860a;
   int err_total = 0;
   int n_compared = 0;
   // expected function code per register; byte k is field k/3 holding code k%3+1
   logic [95:0] route_tab [N_REGS] = '{96'h0004_0000_0000_0000_0000_0000,
      96'h0000_0000_0100_0002_0000_0300, 96'h0, 96'h0009_0500_0008_0000_0a00_000c,
      96'h150f_1014_0e11_130d_0f00_0b06, 96'h191a_1800_1b17_001d_1e16_1112,
      96'h0000_2000_0021_0000_2200_001f, 96'h0000_1900_001c_0000_1200_0010,
      96'h0000_1d00_1406_0013_0500_0007, 96'h0000_0000_1600_0015_0000_001a};
   pin_function_mux i_pin_function_mux (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .gpio_drive(gpio_drive), .gpio_in(gpio_in),
      .periph_drive(periph_drive), .periph_in(periph_in), .periph_routed(periph_routed),
      .ext_count_clk_ch5(ext_count_clk_ch5), .ext_count_clk_ch6(ext_count_clk_ch6),
      .pad_in(pad_in), .pad_drive(pad_drive));
   pad_model i_pad_model (.pad_drive(pad_drive), .ext_level(ext_level), .pad_in(pad_in));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // one bus cycle; the strobe stays up until the caller's next cycle replaces it
   task automatic op(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge ref_clk);
   endtask
   task automatic idle();
      op(16'h0000, 8'h00, 1'b0, 1'b0);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      op(a, d, 1'b1, 1'b0);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] got);
      op(a, 8'h00, 1'b0, 1'b1);
      bus_req.rd <= 1'b0;
      @(negedge ref_clk);
      got = bus_rdata;
      @(posedge ref_clk);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [N_PINS-1:0] got, input logic [N_PINS-1:0] exp,
      input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // random peripheral, gpio and board traffic on every rising edge
   always @(posedge ref_clk) begin
      gpio_drive <= 78'({rnd(), rnd(), rnd()});
      periph_drive <= 70'({rnd(), rnd(), rnd()});
      ext_level <= 39'({rnd(), rnd()});
   end
   // a hang costs at most 5000 cycles, about five times the thousand or so the tests use
   initial begin
      #500_000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      logic [7:0] got, d, f;
      logic [1:0] pv;
      logic pp;
      int pin;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // reset values, then random bytes read straight after each write
      for (int r = 0; r < N_REGS; r++) begin
         rd(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), got);
         chk8(got, 8'h00, "reset value");
      end
      for (int r = 0; r < N_REGS; r++) begin
         d = 8'(rnd());
         wr(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), d);
         rd(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), got);
         chk8(got, d, "read back");
         wr(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), 8'h00);
      end
      wr(16'h52a1, 8'hff);
      rd(16'h52a1, got);
      chk8(got, 8'h00, "unmapped read");
      // codes 1 to 3 of every pin field alone; reserved ones must leave the pin on gpio
      for (int r = 0; r < N_REGS; r++) begin
         for (int k = 0; k < 12; k++) begin
            if (r == N_REGS - 1 && k > 8) continue;
            f = route_tab[r][k*8 +: 8];
            pin = r * 4 + k / 3;
            wr(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), 8'(k % 3 + 1) << (2 * (k / 3)));
            idle();
            @(negedge ref_clk);
            chk_vec(39'(periph_routed) & ~39'h1, f != 0 ? 39'h1 << f : 39'h0, "route");
            pv = f != 0 ? {periph_drive.out[f], periph_drive.oe[f]}
               : {gpio_drive.out[pin], gpio_drive.oe[pin]};
            pp = pad_in[pin];
            @(negedge ref_clk);
            chk_vec(39'({pad_drive.out[pin], pad_drive.oe[pin]}), 39'(pv), "pin drive");
            repeat (2) @(negedge ref_clk);
            if (f != 0)
               chk_vec(39'(periph_in[f]), 39'(pp), "periph input");
            @(posedge ref_clk);
            wr(PORT1_LOW_PIN_FUNCTION_OFS + 16'(r), 8'h00);
         end
      end
      // each clock source choice, then busy source pins hold both clocks low
      for (int s = 0; s < 4; s++) begin
         wr(16'h52ab, 8'(s) << 6);
         idle();
         repeat (6) @(posedge ref_clk);
      end
      wr(16'h52ab, 8'h00);
      wr(16'h52a7, 8'hd0);
      idle();
      repeat (4) @(posedge ref_clk);
      repeat (8) begin
         @(negedge ref_clk);
         chk_vec(39'({ext_count_clk_ch6, ext_count_clk_ch5}), 39'h0, "ext clock");
      end
      @(posedge ref_clk);
      conclude();
   end
endmodule
